/* common/isshb_pkg.sv */
/*
 * Constants, state codes and carrier structs for the serial-port slave with
 * clock stretching, address/data hold and 10-bit addressing.
 * Assumes a single system clock with a synchronous active-high reset.
 */
// Notes on behaviour
// - address hold: after 8th SCL fall of matching address, release bit cleared, irq set
// - start sets start-seen; irq only when start interrupts are enabled
// - ack-timing, read/write and data/address flags tell the irq source
// - software read of the buffer clears buffer-full
// - during address hold the software ack value is driven on SDA while SCL is still held
// - writing transmit data sets buffer-full; load only after address ack
// - master acknowledge after each sent byte lands in received-ack status
// - master NACK on a sent byte: stop stretching, free the bus
// - 10-bit matching high byte, write: update-address set, acked, irq set
// - update-address stretch holds SCL without clearing the release bit
// - writing the slave address during update-address stretch frees SCL at once if the release bit is set
// - 10-bit low mismatch: irq and update-address set, buffer-full not set, release unchanged
// - 10-bit receive with stretch enable: release bit cleared after each acked data byte
// - 10-bit hold modes use the same stretch timing as 7-bit
// - cleared release bit holds SCL only once SCL is low; setting frees it
// - after acking a read address the release bit is cleared automatically
// - stretch enable: stretch after every acknowledge until software releases
// - data hold: release bit cleared after 8th SCL fall of each received data byte
package isshb_pkg;

	localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
	localparam logic [7:0] BUFFER_RESET     = 8'h00;
	localparam logic [4:0] TEN_BIT_PREFIX   = 5'h1E;
	localparam logic [3:0] LAST_BIT         = 4'h8;
	localparam logic [2:0] SYNC_IDLE        = 3'h7;
	localparam logic [2:0] TOP_BIT          = 3'h7;
	localparam logic [1:0] PH_NONE          = 2'h0;
	localparam logic [1:0] PH_HIGH          = 2'h1;
	localparam logic [1:0] PH_MATCHED       = 2'h2;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_ACK   = 7'h04,
		ST_RX    = 7'h08,
		ST_TX    = 7'h10,
		ST_TXACK = 7'h20,
		ST_SKIP  = 7'h40
	} isshb_state_t;

	typedef struct packed {
		logic address_hold_enable;
		logic data_hold_enable;
		logic stretch_enable;
		logic ten_bit_mode;
		logic start_irq_enable;
		logic ack_value_to_send;
	} isshb_ctrl_t;

	typedef struct packed {
		logic irq_clear;
		logic buf_read;
		logic buf_write;
		logic release_set;
		logic release_clear;
		logic addr_write;
	} isshb_strobe_t;

	typedef struct packed {
		logic serial_irq_flag;
		logic buffer_full_flag;
		logic clock_release_bit;
		logic ack_timing_flag;
		logic read_write_flag;
		logic data_address_flag;
		logic received_ack_status;
		logic update_address_flag;
		logic start_seen;
		logic stop_seen;
	} isshb_status_t;

endpackage : isshb_pkg

/* design/isshb_slave.sv */
/*
 * Slave engine: address match (7/10-bit), receive, transmit, hold points,
 * clock stretching and the software-visible flags.
 * Assumes open-drain SCL/SDA resolved outside; software pulses the strobes.
 * Pin edges come from the synchronised levels, so every bus event is seen
 * three to four clocks after the wire moves.
 */
`timescale 1ns/1ps
module isshb_slave (
	input  wire logic                  clk,                    // system clock
	input  wire logic                  reset,                  // sync reset, active high
	input  wire logic                  scl_in,                 // SCL pin level
	output logic                       scl_out,                // SCL drive value, always low
	output logic                       scl_oe_n,               // low while pulling SCL
	input  wire logic                  sda_in,                 // SDA pin level
	output logic                       sda_out,                // SDA drive value, always low
	output logic                       sda_oe_n,               // low while pulling SDA
	input  wire isshb_pkg::isshb_ctrl_t   sw_ctrl,             // software configuration
	input  wire isshb_pkg::isshb_strobe_t sw_strobe,           // software action pulses
	input  wire logic [7:0]            sw_wdata,               // data for buffer/address writes
	output logic [7:0]                 transfer_buffer,        // buffer contents
	output logic [7:0]                 slave_address_register, // address register
	output isshb_pkg::isshb_status_t   port_status             // flags
);

	typedef struct packed {
		isshb_pkg::isshb_state_t  fsm;
		isshb_pkg::isshb_status_t status;
		logic [2:0]               scl_s;
		logic [2:0]               sda_s;
		logic                     scl_f;
		logic                     sda_f;
		logic [3:0]               bitcnt;
		logic [7:0]               shift;
		logic [7:0]               buffer;
		logic [7:0]               slave_address;
		logic [1:0]               phase;
		logic                     use_sw_ack;
		logic                     ack_ok;
		logic                     low_miss;
		logic                     ua_stretch;
		logic                     scl_hold_n;
		logic                     sda_hold_n;
	} isshb_regs_t;

	isshb_regs_t st;
	isshb_regs_t n;

	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic sda_rise;
		logic sda_fall;
		logic hi_ok;
		logic match;
		logic acked;
		logic hold_req;
		logic line_low;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		sda_rise = 1'b0;
		sda_fall = 1'b0;
		hi_ok = 1'b0;
		match = 1'b0;
		acked = ~st.sda_hold_n;
		hold_req = 1'b0;
		line_low = 1'b0;
		n = st;

		// pin sampling: a level counts once 2nd and 3rd stage agree
		n.scl_s = {st.scl_s[1:0], scl_in};
		n.sda_s = {st.sda_s[1:0], sda_in};
		if (st.scl_s[1] == st.scl_s[2]) begin
			n.scl_f = st.scl_s[2];
			scl_rise = st.scl_s[2] & ~st.scl_f;
			scl_fall = ~st.scl_s[2] & st.scl_f;
		end
		if (st.sda_s[1] == st.sda_s[2]) begin
			n.sda_f = st.sda_s[2];
			sda_rise = st.sda_s[2] & ~st.sda_f;
			sda_fall = ~st.sda_s[2] & st.sda_f;
		end

		// software actions first, so hardware events of the same cycle win
		if (sw_strobe.irq_clear)
			n.status.serial_irq_flag = 1'b0;
		if (sw_strobe.buf_read)
			n.status.buffer_full_flag = 1'b0;
		if (sw_strobe.buf_write) begin
			n.buffer = sw_wdata;
			n.status.buffer_full_flag = 1'b1;
		end
		if (sw_strobe.addr_write) begin
			n.slave_address = sw_wdata;
			n.ua_stretch = 1'b0;
			n.status.update_address_flag = 1'b0;
		end
		if (sw_strobe.release_clear)
			n.status.clock_release_bit = 1'b0;
		if (sw_strobe.release_set)
			n.status.clock_release_bit = 1'b1;

		// address compare on the byte now in the shifter
		// high byte: fixed prefix plus the two upper address bits
		hi_ok = (st.shift[7:3] == isshb_pkg::TEN_BIT_PREFIX) && (st.shift[2:1] == st.slave_address[2:1]);
		// low byte compares all eight bits, 7-bit mode skips the direction bit
		if (!sw_ctrl.ten_bit_mode)
			match = st.shift[7:1] == st.slave_address[7:1];
		else if (st.phase == isshb_pkg::PH_HIGH)
			match = st.shift == st.slave_address;
		else
			match = hi_ok && (!st.shift[0] || st.phase == isshb_pkg::PH_MATCHED);

		case (st.fsm)
			// shift in address or data on SCL rise; byte ends on the 8th fall
			isshb_pkg::ST_ADDR, isshb_pkg::ST_RX: begin
				if (scl_rise) begin
					n.shift = {st.shift[6:0], st.sda_f};
					n.bitcnt = st.bitcnt + 4'h1;
				end
				if (scl_fall && st.bitcnt == isshb_pkg::LAST_BIT) begin
					n.fsm = isshb_pkg::ST_ACK;
					n.ack_ok = ~st.status.buffer_full_flag;
					n.low_miss = 1'b0;
					// data byte: hold point only with data hold
					if (st.fsm == isshb_pkg::ST_RX) begin
						if (!st.status.buffer_full_flag)
							n.buffer = st.shift;
						n.status.buffer_full_flag = 1'b1;
						n.status.data_address_flag = 1'b1;
						n.use_sw_ack = sw_ctrl.data_hold_enable;
						if (sw_ctrl.data_hold_enable) begin
							n.status.clock_release_bit = 1'b0;
							n.status.serial_irq_flag = 1'b1;
							n.status.ack_timing_flag = 1'b1;
						end
					end else if (match) begin
						if (!st.status.buffer_full_flag)
							n.buffer = st.shift;
						n.status.buffer_full_flag = 1'b1;
						n.status.data_address_flag = 1'b0;
						if (!(sw_ctrl.ten_bit_mode && st.phase == isshb_pkg::PH_HIGH))
							n.status.read_write_flag = st.shift[0];
						n.use_sw_ack = sw_ctrl.address_hold_enable;
						if (sw_ctrl.address_hold_enable) begin
							n.status.clock_release_bit = 1'b0;
							n.status.serial_irq_flag = 1'b1;
							n.status.ack_timing_flag = 1'b1;
						end
					end else if (sw_ctrl.ten_bit_mode && st.phase == isshb_pkg::PH_HIGH) begin
						// low byte missed: nack, no buffer load, release bit untouched
						n.low_miss = 1'b1;
						n.ack_ok = 1'b0;
						n.use_sw_ack = 1'b0;
					end else begin
						n.fsm = isshb_pkg::ST_SKIP;
					end
				end
			end
			// acknowledge bit stands until the 9th fall
			isshb_pkg::ST_ACK: begin
				n.sda_hold_n = st.use_sw_ack ? sw_ctrl.ack_value_to_send : ~st.ack_ok;
				if (scl_rise)
					n.status.ack_timing_flag = 1'b0;
				if (scl_fall) begin
					n.sda_hold_n = 1'b1;
					n.bitcnt = 4'h0;
					if (st.low_miss) begin
						n.status.serial_irq_flag = 1'b1;
						n.status.update_address_flag = 1'b1;
						n.ua_stretch = 1'b1;
						n.fsm = isshb_pkg::ST_SKIP;
					end else if (!acked) begin
						n.fsm = isshb_pkg::ST_SKIP;
					end else begin
						n.status.serial_irq_flag = 1'b1;
						n.fsm = isshb_pkg::ST_RX;
						if (st.status.data_address_flag) begin
							if (sw_ctrl.stretch_enable)
								n.status.clock_release_bit = 1'b0;
						end else if (sw_ctrl.ten_bit_mode && st.phase != isshb_pkg::PH_MATCHED) begin
							// high then low byte: both wait for an address rewrite
							n.status.update_address_flag = 1'b1;
							n.ua_stretch = 1'b1;
							n.phase = (st.phase == isshb_pkg::PH_HIGH) ? isshb_pkg::PH_MATCHED : isshb_pkg::PH_HIGH;
							if (st.phase != isshb_pkg::PH_HIGH)
								n.fsm = isshb_pkg::ST_ADDR;
						end else if (st.status.read_write_flag) begin
							n.status.clock_release_bit = 1'b0;
							n.fsm = isshb_pkg::ST_TX;
						end else if (sw_ctrl.stretch_enable) begin
							n.status.clock_release_bit = 1'b0;
						end
					end
				end
			end
			// send buffer MSB first
			isshb_pkg::ST_TX: begin
				// change SDA only while SCL is low so data is valid while high
				if (!st.scl_f && st.bitcnt < isshb_pkg::LAST_BIT)
					n.sda_hold_n = st.buffer[isshb_pkg::TOP_BIT - st.bitcnt[2:0]];
				if (scl_rise)
					n.bitcnt = st.bitcnt + 4'h1;
				if (scl_fall && st.bitcnt == isshb_pkg::LAST_BIT) begin
					n.sda_hold_n = 1'b1;
					n.status.buffer_full_flag = 1'b0;
					n.status.data_address_flag = 1'b1;
					n.fsm = isshb_pkg::ST_TXACK;
				end
			end
			// master answer on the 9th clock
			isshb_pkg::ST_TXACK: begin
				// ack from master sampled on the 9th rise
				if (scl_rise)
					n.status.received_ack_status = st.sda_f;
				if (scl_fall) begin
					n.status.serial_irq_flag = 1'b1;
					n.bitcnt = 4'h0;
					if (!st.status.received_ack_status) begin
						// master wants more: stretch until software sets the release bit
						n.status.clock_release_bit = 1'b0;
						n.fsm = isshb_pkg::ST_TX;
					end else begin
						// nack: drop off the bus without stretching
						n.fsm = isshb_pkg::ST_SKIP;
					end
				end
			end
			// not addressed: keep SDA free until the next start
			isshb_pkg::ST_IDLE, isshb_pkg::ST_SKIP: begin
				n.sda_hold_n = 1'b1;
			end
			// illegal code: recover to idle
			default: begin
				n.fsm = isshb_pkg::ST_IDLE;
			end
		endcase

		// bus conditions override any byte in progress
		if (sda_fall && st.scl_f) begin
			n.fsm = isshb_pkg::ST_ADDR;
			n.bitcnt = 4'h0;
			n.sda_hold_n = 1'b1;
			n.status.start_seen = 1'b1;
			n.status.stop_seen = 1'b0;
			if (sw_ctrl.start_irq_enable)
				n.status.serial_irq_flag = 1'b1;
			if (n.phase == isshb_pkg::PH_HIGH)
				n.phase = isshb_pkg::PH_NONE;
		end else if (sda_rise && st.scl_f) begin
			n.fsm = isshb_pkg::ST_IDLE;
			n.sda_hold_n = 1'b1;
			n.phase = isshb_pkg::PH_NONE;
			n.status.stop_seen = 1'b1;
			n.status.start_seen = 1'b0;
		end

		// hold SCL only once it is already low; release at once when freed
		// a hold is wanted while the release bit is clear or an address update is pending
		hold_req = ~n.status.clock_release_bit | n.ua_stretch;
		// pull SCL only when it is already low, or keep pulling it
		line_low = ~st.scl_hold_n | ~st.scl_f;
		n.scl_hold_n = ~(line_low & hold_req);

		// reset last so it overrides every path above
		if (reset) begin
			n = '0;
			n.fsm = isshb_pkg::ST_IDLE;
			n.status.clock_release_bit = 1'b1;
			n.scl_s = isshb_pkg::SYNC_IDLE;
			n.sda_s = isshb_pkg::SYNC_IDLE;
			n.scl_f = 1'b1;
			n.sda_f = 1'b1;
			n.scl_hold_n = 1'b1;
			n.sda_hold_n = 1'b1;
			n.buffer = isshb_pkg::BUFFER_RESET;
			n.slave_address = isshb_pkg::SLAVE_ADDR_RESET;
			n.phase = isshb_pkg::PH_NONE;
		end
	end

	// one register stage holds all state
	always_ff @(posedge clk) begin
		st <= n;
	end

	// open drain: value is always low, only the enables move
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = st.scl_hold_n;
	assign sda_oe_n = st.sda_hold_n;
	assign transfer_buffer = st.buffer;
	assign slave_address_register = st.slave_address;
	assign port_status = st.status;

endmodule : isshb_slave

/* verif/isshb_master.sv */
/* Behavioural bus master: start, stop, byte write and read, 300/100 ns clock.
   Assumes the bench resolves the open-drain wires with pull-ups. */
`timescale 1ns/1ps
module isshb_master (
	input  wire logic scl,   // resolved clock wire
	input  wire logic sda,   // resolved data wire
	output logic      m_scl, // 0 pulls clock
	output logic      m_sda, // 0 pulls data
	output logic      stuck  // clock held past limit
);
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
		stuck = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		int n;
		#100 m_sda = b;
		#200 m_scl = 1'b1;
		n = 0;
		while (scl !== 1'b1 && n < 4000) begin
			#10 n = n + 1;
		end
		if (n == 4000) stuck = 1'b1;
		#90 s = sda;
		#10 m_scl = 1'b0;
	endtask : bit_io
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, ack);
	endtask : wr
	// caller answers the last byte with nack
	task automatic rd(output logic [7:0] d, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d = {d[6:0], s};
		end
		bit_io(ack, s);
	endtask : rd
	task automatic start_c;
		#100 m_sda = 1'b0;
		#200 m_scl = 1'b0;
	endtask : start_c
	task automatic stop_c;
		#100 m_sda = 1'b0;
		#200 m_scl = 1'b1;
		#100 m_sda = 1'b1;
		#400;
	endtask : stop_c
endmodule : isshb_master

/* verif/isshb_properties.sv */
/* Checker for the slave's port timing and flag relations.
   Assumes it is bound onto isshb_slave and sees only its ports. */
`timescale 1ns/1ps
module isshb_checker (
	input wire logic                     clk,             // system clock
	input wire logic                     reset,           // sync reset
	input wire logic                     scl_out,         // clock drive value
	input wire logic                     scl_oe_n,        // clock pull, low active
	input wire logic                     sda_out,         // data drive value
	input wire logic                     sda_oe_n,        // data pull, low active
	input wire isshb_pkg::isshb_ctrl_t   sw_ctrl,         // configuration
	input wire isshb_pkg::isshb_strobe_t sw_strobe,       // software pulses
	input wire logic [7:0]               sw_wdata,        // write data
	input wire logic [7:0]               transfer_buffer, // buffer
	input wire isshb_pkg::isshb_status_t port_status      // flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_PULL_LOW: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("line driven high");
	AST_RELEASE: assert property (sw_strobe.release_set && !scl_oe_n && !port_status.update_address_flag |-> ##[1:2] scl_oe_n)
		else $error("clock not freed by release");
	AST_UA_FREE: assert property (sw_strobe.addr_write && !scl_oe_n && port_status.update_address_flag |-> ##[1:2] scl_oe_n)
		else $error("clock not freed by address write");
	AST_UA_KEEP: assert property ($rose(port_status.update_address_flag) && !sw_ctrl.address_hold_enable |-> $stable(port_status.clock_release_bit))
		else $error("release bit changed with update flag");
	AST_BUF_READ: assert property (sw_strobe.buf_read && !scl_oe_n |=> !port_status.buffer_full_flag)
		else $error("buffer read left full flag");
	AST_BUF_WRITE: assert property (sw_strobe.buf_write && !scl_oe_n && !port_status.buffer_full_flag |=> port_status.buffer_full_flag && transfer_buffer == $past(sw_wdata))
		else $error("buffer write not taken");
	AST_START_IRQ: assert property ($rose(port_status.start_seen) && sw_ctrl.start_irq_enable |-> ##[0:1] port_status.serial_irq_flag)
		else $error("start without irq");
	AST_HOLD_IRQ: assert property ($fell(port_status.clock_release_bit) && !$past(sw_strobe.release_clear) |-> port_status.serial_irq_flag)
		else $error("hold without irq");
	AST_NACK_FREE: assert property ($rose(port_status.received_ack_status) |-> scl_oe_n [*8])
		else $error("clock held after nack");
	AST_ACK_VALUE: assert property ($fell(sda_oe_n) && port_status.ack_timing_flag |-> !sw_ctrl.ack_value_to_send)
		else $error("ack drive against ack value");
endmodule : isshb_checker
bind isshb_slave isshb_checker isshb_checker_i (.clk(clk), .reset(reset), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .sw_ctrl(sw_ctrl), .sw_strobe(sw_strobe), .sw_wdata(sw_wdata),
	.transfer_buffer(transfer_buffer), .port_status(port_status));

/* verif/tb_top.sv */
/* Bench: software pulses plus bus master exercise hold, transmit and 10-bit paths.
   Assumes the pull-ups of both wires are modelled here. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_top;
	localparam logic [5:0] IRQ_CLR = 6'h20, RD = 6'h10, WR = 6'h08, REL = 6'h04, ADDR = 6'h01;
	logic clk, reset, scl, sda, m_scl, m_sda, stuck, ack, scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic [7:0] d, buf_q, addr_q, wdata;
	isshb_pkg::isshb_ctrl_t   ctrl;
	isshb_pkg::isshb_strobe_t stb;
	isshb_pkg::isshb_status_t st;
	int mismatches, num_checks;
	assign scl = m_scl & (scl_oe_n | scl_out);
	assign sda = m_sda & (sda_oe_n | sda_out);
	isshb_slave isshb_slave_i (.clk(clk), .reset(reset), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sw_ctrl(ctrl), .sw_strobe(stb), .sw_wdata(wdata),
		.transfer_buffer(buf_q), .slave_address_register(addr_q), .port_status(st));
	isshb_master isshb_master_i (.scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda), .stuck(stuck));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic pulse(input logic [5:0] s, input logic [7:0] v);
		@(posedge clk);
		#5;
		stb = s;
		wdata = v;
		@(posedge clk);
		#5;
		stb = '0;
	endtask : pulse
	task automatic wait_hold;
		int n;
		n = 0;
		while (scl_oe_n !== 1'b0 && n < 400) begin
			@(posedge clk);
			#5;
			n = n + 1;
		end
		if (n == 400) begin
			mismatches++;
			complete_run;
		end
	endtask : wait_hold
	task automatic t_read_hold;
		ctrl = 6'h22;
		pulse(ADDR, 8'hA4);
		isshb_master_i.start_c();
		`CHK("start", 2'h3, {st.start_seen, st.serial_irq_flag})
		pulse(IRQ_CLR, 8'h00);
		fork
			isshb_master_i.wr(8'hA5, ack);
			begin
				wait_hold;
				`CHK("rel", 2'h1, {st.clock_release_bit, st.serial_irq_flag})
				`CHK("flags", 3'h6, {st.ack_timing_flag, st.read_write_flag, st.data_address_flag})
				`CHK("buf", 8'hA5, buf_q)
				pulse(RD, 8'h00);
				`CHK("bf", 1'b0, st.buffer_full_flag)
				pulse(IRQ_CLR | REL, 8'h00);
			end
		join
		`CHK("ack", 1'b0, ack)
		wait_hold;
		`CHK("rel", 1'b0, st.clock_release_bit)
		pulse(WR, 8'h3C);
		`CHK("bf", 1'b1, st.buffer_full_flag)
		pulse(REL, 8'h00);
		isshb_master_i.rd(d, 1'b0);
		`CHK("data", 8'h3C, d)
		wait_hold;
		`CHK("received_ack_status", 1'b0, st.received_ack_status)
		pulse(WR, 8'hC3);
		pulse(REL, 8'h00);
		isshb_master_i.rd(d, 1'b1);
		`CHK("data", 8'hC3, d)
		repeat (20) @(posedge clk);
		`CHK("received_ack_status", 1'b1, st.received_ack_status)
		`CHK("free", 1'b1, scl_oe_n)
		isshb_master_i.stop_c();
		`CHK("stop", 1'b1, st.stop_seen)
		$display("test read_hold done");
	endtask : t_read_hold
	task automatic t_ten_bit;
		ctrl = 6'h0C;
		pulse(ADDR, 8'hF4);
		isshb_master_i.start_c();
		isshb_master_i.wr(8'hF4, ack);
		wait_hold;
		`CHK("ua", 3'h6, {st.update_address_flag, st.serial_irq_flag, ack})
		`CHK("rel", 1'b1, st.clock_release_bit)
		pulse(IRQ_CLR | RD, 8'h00);
		pulse(ADDR, 8'h5A);
		isshb_master_i.wr(8'h5B, ack);
		wait_hold;
		`CHK("miss", 4'hD, {st.update_address_flag, st.serial_irq_flag, st.buffer_full_flag, ack})
		`CHK("rel", 1'b1, st.clock_release_bit)
		pulse(IRQ_CLR | ADDR, 8'hF4);
		isshb_master_i.stop_c();
		isshb_master_i.start_c();
		isshb_master_i.wr(8'hF4, ack);
		wait_hold;
		pulse(IRQ_CLR | RD | ADDR, 8'h5A);
		isshb_master_i.wr(8'h5A, ack);
		wait_hold;
		`CHK("lo", 2'h2, {st.update_address_flag, ack})
		pulse(IRQ_CLR | RD | ADDR, 8'hF4);
		isshb_master_i.wr(8'h77, ack);
		wait_hold;
		`CHK("rel", 1'b0, st.clock_release_bit)
		`CHK("buf", 8'h77, buf_q)
		pulse(RD | REL, 8'h00);
		isshb_master_i.stop_c();
		$display("test ten_bit done");
	endtask : t_ten_bit
	task automatic t_data_hold;
		ctrl = 6'h10;
		pulse(IRQ_CLR | ADDR, 8'hA4);
		isshb_master_i.start_c();
		`CHK("start", 2'h2, {st.start_seen, st.serial_irq_flag})
		isshb_master_i.wr(8'hA4, ack);
		`CHK("ack", 1'b0, ack)
		pulse(IRQ_CLR | RD, 8'h00);
		fork
			isshb_master_i.wr(8'h96, ack);
			begin
				wait_hold;
				`CHK("hold", 4'h7, {st.clock_release_bit, st.serial_irq_flag, st.data_address_flag, st.ack_timing_flag})
				`CHK("buf", 8'h96, buf_q)
				pulse(IRQ_CLR | RD | REL, 8'h00);
			end
		join
		`CHK("ack", 1'b0, ack)
		isshb_master_i.stop_c();
		$display("test data_hold done");
	endtask : t_data_hold
	initial begin
		reset = 1'b1;
		ctrl = '0;
		stb = '0;
		wdata = 8'h00;
		mismatches = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		#5;
		reset = 1'b0;
		`CHK("rst", 2'h3, {st.clock_release_bit, scl_oe_n})
		repeat (4) @(posedge clk);
		t_read_hold;
		t_ten_bit;
		t_data_hold;
		`CHK("stuck", 1'b0, stuck)
		complete_run;
	end
endmodule : tb_top
